// ===== rtl/tpo_pkg.sv
// Purpose: shared constants for the triggered pulse output port
// Assumes: 32-bit apb, one word per register
// Notes: offsets are byte addresses
package tpo_pkg;
  localparam int TPO_AW = 8;
  localparam int TPO_TW = 16;
  localparam int TPO_PW = 8;
  localparam logic [7:0] TPO_OFF_CTRL = 8'h00;
  localparam logic [7:0] TPO_OFF_DATA0 = 8'h04;
  localparam logic [7:0] TPO_OFF_DATA1 = 8'h08;
  localparam logic [7:0] TPO_OFF_T0RLD = 8'h0c;
  localparam logic [7:0] TPO_OFF_T3RLD = 8'h10;
  localparam logic [7:0] TPO_OFF_TSTART = 8'h14;
  localparam logic [7:0] TPO_OFF_FLAGS = 8'h18;
  localparam logic [7:0] TPO_OFF_PWM1 = 8'h1c;
  localparam logic [7:0] TPO_OFF_PWM2 = 8'h20;
  localparam logic [7:0] TPO_OFF_PWM4 = 8'h24;
  localparam logic [7:0] TPO_OFF_STAT = 8'h28;
  localparam logic [7:0] TPO_OFF_PRESC = 8'h2c;
  // ctrl field positions
  localparam int TPO_C_WSEL_LO = 0;
  localparam int TPO_C_PMODE = 3;
  localparam int TPO_C_TSEL_LO = 4;
  localparam int TPO_C_OUTEN = 7;
  localparam int TPO_C_PINSEL = 8;
  localparam int TPO_C_EDGE_LO = 9;
  localparam int TPO_C_PWMEN = 11;
  localparam int TPO_C_T4PIN = 12;
  localparam int TPO_CTRL_W = 13;
  localparam logic [TPO_CTRL_W-1:0] TPO_CTRL_RST = 13'h0000;
  localparam logic [2:0] TPO_WSEL_PULSE = 3'h1;
  localparam logic [1:0] TPO_TSEL_INT = 2'h0;
  localparam logic [1:0] TPO_EDGE_FALL = 2'h0;
  localparam logic [1:0] TPO_EDGE_RISE = 2'h1;
  // flag positions
  localparam int TPO_F_T0 = 0;
  localparam int TPO_F_T3 = 1;
  localparam int TPO_F_EXT3 = 2;
  localparam int TPO_NFLAG = 3;
  localparam logic [TPO_TW-1:0] TPO_RLD_RST = 16'hffff;
  localparam logic [7:0] TPO_PRESC_RST = 8'h00;
  localparam logic [15:0] TPO_PWM_RST = 16'h0000;
endpackage

// ===== rtl/tpo_tmr_if.sv
// Purpose: link between the port core and one reload timer
// Assumes: single pclk domain
// Notes: tick is a one-cycle count-source enable
interface tpo_tmr_if #(parameter int W = 16);
  logic start;
  logic tick;
  logic [W-1:0] reload;
  logic [W-1:0] count;
  logic uf;
  modport ctl (output start, output tick, output reload, input count, input uf);
  modport tmr (input start, input tick, input reload, output count, output uf);
endinterface

// ===== rtl/tpo_timer.sv
// Purpose: reload down-counter, underflow pulse on passing zero
// Assumes: tick enable from the core's divider
// Notes: stopped counter keeps its reload value preloaded
module tpo_timer #(parameter int W = 16) (
  input wire logic pclk,
  input wire logic presetn,
  tpo_tmr_if.tmr bus
);
  logic [W-1:0] cnt_r;
  logic uf_r;

  assign bus.count = cnt_r;
  assign bus.uf = uf_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!bus.start) begin
      cnt_r <= bus.reload;
    end else if (bus.tick) begin
      if (cnt_r == '0) begin
        cnt_r <= bus.reload;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uf_r <= 1'b0;
    end else begin
      uf_r <= bus.start && bus.tick && (cnt_r == '0);
    end
  end
endmodule

// ===== rtl/tpo_top.sv
// Purpose: timed pulse output port with apb registers
// Assumes: pins synchronous to pclk; apb answers after one access cycle
// Notes: pwm sources are small internal timers 1, 2 and 4
//
// The register addresses and the APB slave port were decided locally.
module tpo_top #(
  parameter int NA = 4,
  parameter int NB = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trigger_input,
  input wire logic ext_trigger_alt_input,
  input wire logic output_cutoff_input,
  input wire logic [tpo_pkg::TPO_NFLAG-1:0] irq_accept,
  output logic [NA-1:0] group_a_pulse_outputs,
  output logic [NA-1:0] group_a_pulse_oe,
  output logic [NB-1:0] group_b_pulse_outputs,
  output logic [NB-1:0] group_b_pulse_oe,
  output logic timer_four_pwm_pin,
  output logic timer_four_pwm_oe,
  output logic [tpo_pkg::TPO_NFLAG-1:0] irq_request
);
  import tpo_pkg::*;

  function automatic logic [3:0] reg_index(input logic [31:0] a);
    logic [3:0] idx;
    idx = 4'hf;
    if (a[31:TPO_AW] == '0 && a[1:0] == 2'b00) begin
      case (a[TPO_AW-1:0])
        TPO_OFF_CTRL: idx = 4'h0;
        TPO_OFF_DATA0: idx = 4'h1;
        TPO_OFF_DATA1: idx = 4'h2;
        TPO_OFF_T0RLD: idx = 4'h3;
        TPO_OFF_T3RLD: idx = 4'h4;
        TPO_OFF_TSTART: idx = 4'h5;
        TPO_OFF_FLAGS: idx = 4'h6;
        TPO_OFF_PWM1: idx = 4'h7;
        TPO_OFF_PWM2: idx = 4'h8;
        TPO_OFF_PWM4: idx = 4'h9;
        TPO_OFF_STAT: idx = 4'ha;
        TPO_OFF_PRESC: idx = 4'hb;
        default: idx = 4'hf;
      endcase
    end
    return idx;
  endfunction

  logic [TPO_CTRL_W-1:0] ctrl_r;
  logic [NA-1:0] data0_r;
  logic [NB-1:0] data1_r;
  logic [TPO_TW-1:0] t0_rld_r;
  logic [TPO_TW-1:0] t3_rld_r;
  logic [1:0] tstart_r;
  logic [TPO_NFLAG-1:0] flag_r;
  logic [15:0] pwm_cfg_r [3];
  logic [7:0] presc_r;
  logic [7:0] div_r;
  logic tick_r;
  logic [NA-1:0] latch_a_r;
  logic [NB-1:0] latch_b_r;
  logic trg_prev_r;
  logic alt_rise_r;
  logic cut_prev_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  logic setup;
  logic wr_en;
  logic [3:0] widx;
  logic mode_on;
  logic ext_sel;
  logic trg_pin;
  logic rise;
  logic fall;
  logic ext_edge;
  logic trig_a;
  logic trig_b;
  logic cut_fall;
  logic [2:0] pwm_lvl;
  logic [2:0] pwm_hi;

  tpo_tmr_if #(.W(TPO_TW)) t0_if ();
  tpo_tmr_if #(.W(TPO_TW)) t3_if ();

  tpo_timer #(.W(TPO_TW)) u_t0 (.pclk(pclk), .presetn(presetn), .bus(t0_if.tmr));
  tpo_timer #(.W(TPO_TW)) u_t3 (.pclk(pclk), .presetn(presetn), .bus(t3_if.tmr));

  assign t0_if.start = tstart_r[0];
  assign t3_if.start = tstart_r[1];
  assign t0_if.tick = tick_r;
  assign t3_if.tick = tick_r;
  assign t0_if.reload = t0_rld_r;
  assign t3_if.reload = t3_rld_r;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;
  assign widx = reg_index(paddr);

  // software is expected to pick the pulse mode before the rest
  assign mode_on = (ctrl_r[TPO_C_WSEL_LO +: 3] == TPO_WSEL_PULSE);
  assign ext_sel = (ctrl_r[TPO_C_TSEL_LO +: 2] != TPO_TSEL_INT);
  // trigger pin direction is left to the port logic outside
  assign trg_pin = ctrl_r[TPO_C_PINSEL] ? ext_trigger_alt_input
                                        : ext_trigger_input;
  assign rise = trg_pin && !trg_prev_r;
  assign fall = !trg_pin && trg_prev_r;

  always_comb begin
    case (ctrl_r[TPO_C_EDGE_LO +: 2])
      TPO_EDGE_FALL: ext_edge = fall;
      TPO_EDGE_RISE: ext_edge = rise;
      default: ext_edge = alt_rise_r ? rise : fall;
    endcase
  end

  assign trig_a = mode_on && (ext_sel ? ext_edge : t0_if.uf);
  assign trig_b = mode_on && t3_if.uf;
  assign cut_fall = !output_cutoff_input && cut_prev_r;

  // count source divider: one tick every presc+1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else if (div_r >= presc_r) begin
      div_r <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // edge history for trigger and cutoff pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_prev_r <= 1'b0;
      cut_prev_r <= 1'b1;
      alt_rise_r <= 1'b0;
    end else begin
      trg_prev_r <= trg_pin;
      cut_prev_r <= output_cutoff_input;
      if (ext_edge && ctrl_r[TPO_C_EDGE_LO + 1]) begin
        alt_rise_r <= !alt_rise_r;
      end
    end
  end

  // pwm timers 1, 2, 4: cfg [7:0] high width, [15:8] period minus one
  generate
    for (genvar k = 0; k < 3; k++) begin : g_pwm
      logic [TPO_PW-1:0] pcnt_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pcnt_r <= '0;
        end else if (!ctrl_r[TPO_C_PWMEN]) begin
          pcnt_r <= '0;
        end else if (tick_r) begin
          if (pcnt_r >= pwm_cfg_r[k][15:8]) begin
            pcnt_r <= '0;
          end else begin
            pcnt_r <= pcnt_r + 1'b1;
          end
        end
      end
      assign pwm_lvl[k] = (pcnt_r < pwm_cfg_r[k][7:0]);
      assign pwm_hi[k] = ctrl_r[TPO_C_PWMEN] ? pwm_lvl[k] : 1'b1;
    end
  endgenerate

  // control register; cutoff clears the enable and blocks setting it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= TPO_CTRL_RST;
    end else begin
      if (wr_en && widx == 4'h0) begin
        ctrl_r <= pwdata[TPO_CTRL_W-1:0];
        if (!output_cutoff_input) begin
          ctrl_r[TPO_C_OUTEN] <= 1'b0;
        end
      end
      if (cut_fall) begin
        ctrl_r[TPO_C_OUTEN] <= 1'b0;
      end
    end
  end

  // data and timer configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data0_r <= '0;
      data1_r <= '0;
      t0_rld_r <= TPO_RLD_RST;
      t3_rld_r <= TPO_RLD_RST;
      tstart_r <= '0;
      presc_r <= TPO_PRESC_RST;
      for (int i = 0; i < 3; i++) begin
        pwm_cfg_r[i] <= TPO_PWM_RST;
      end
    end else if (wr_en) begin
      case (widx)
        4'h1: data0_r <= pwdata[NA-1:0];
        4'h2: data1_r <= pwdata[NB-1:0];
        4'h3: t0_rld_r <= pwdata[TPO_TW-1:0];
        4'h4: t3_rld_r <= pwdata[TPO_TW-1:0];
        4'h5: tstart_r <= pwdata[1:0];
        4'h7: pwm_cfg_r[0] <= pwdata[15:0];
        4'h8: pwm_cfg_r[1] <= pwdata[15:0];
        4'h9: pwm_cfg_r[2] <= pwdata[15:0];
        4'hb: presc_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // request flags: hardware set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
    end else begin
      for (int i = 0; i < TPO_NFLAG; i++) begin
        if (irq_accept[i] || (wr_en && widx == 4'h6 && !pwdata[i])) begin
          flag_r[i] <= 1'b0;
        end
      end
      if (mode_on && !ext_sel && t0_if.uf) begin
        flag_r[TPO_F_T0] <= 1'b1;
      end
      if (mode_on && t3_if.uf) begin
        flag_r[TPO_F_T3] <= 1'b1;
      end
      if (mode_on && ext_sel && ext_edge) begin
        flag_r[TPO_F_EXT3] <= 1'b1;
      end
    end
  end

  // pattern latches: data reaches the pins only on a trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_a_r <= '0;
      latch_b_r <= '0;
    end else begin
      if (trig_a) begin
        latch_a_r <= data0_r;
      end
      if (trig_b) begin
        latch_b_r <= data1_r;
      end
    end
  end

  // pin drivers; group a bits 0-1 use pwm1, 2-3 pwm2, group b pwm4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_a_pulse_outputs <= '0;
      group_a_pulse_oe <= '0;
      group_b_pulse_outputs <= '0;
      group_b_pulse_oe <= '0;
      timer_four_pwm_pin <= 1'b0;
      timer_four_pwm_oe <= 1'b0;
    end else begin
      for (int i = 0; i < NA; i++) begin
        group_a_pulse_outputs[i] <= latch_a_r[i] && pwm_hi[i / 2 % 2];
        group_a_pulse_oe[i] <= mode_on && ctrl_r[TPO_C_OUTEN];
      end
      for (int i = 0; i < NB; i++) begin
        group_b_pulse_outputs[i] <= latch_b_r[i] && pwm_hi[2];
        group_b_pulse_oe[i] <= mode_on && ctrl_r[TPO_C_OUTEN]
                               && ctrl_r[TPO_C_PMODE];
      end
      // pin freed for general use when its enable is clear
      timer_four_pwm_pin <= ctrl_r[TPO_C_PWMEN] && pwm_lvl[2];
      timer_four_pwm_oe <= ctrl_r[TPO_C_T4PIN];
    end
  end

  // apb slave: answer registered at setup, one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && (widx == 4'hf);
      if (setup) begin
        prdata_r <= '0;
        case (widx)
          4'h0: prdata_r[TPO_CTRL_W-1:0] <= ctrl_r;
          4'h1: prdata_r[NA-1:0] <= data0_r;
          4'h2: prdata_r[NB-1:0] <= data1_r;
          4'h3: prdata_r[TPO_TW-1:0] <= t0_if.count;
          4'h4: prdata_r[TPO_TW-1:0] <= t3_if.count;
          4'h5: prdata_r[1:0] <= tstart_r;
          4'h6: prdata_r[TPO_NFLAG-1:0] <= flag_r;
          4'h7: prdata_r[15:0] <= pwm_cfg_r[0];
          4'h8: prdata_r[15:0] <= pwm_cfg_r[1];
          4'h9: prdata_r[15:0] <= pwm_cfg_r[2];
          4'ha: prdata_r[NA+NB:0] <= {output_cutoff_input, latch_b_r, latch_a_r};
          4'hb: prdata_r[7:0] <= presc_r;
          default: ;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_request = flag_r;
endmodule

// ===== sim/tpo_top_asserts.sv
// Purpose: port-level checks of the pulse output port
// Assumes: one pclk domain, sees tpo_top ports only
// Notes: pwm moves pins between triggers, so pwm use is tracked from ctrl writes
module tpo_top_asserts #(
  parameter int NA = 4,
  parameter int NB = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_trigger_input,
  input wire logic ext_trigger_alt_input,
  input wire logic output_cutoff_input,
  input wire logic [tpo_pkg::TPO_NFLAG-1:0] irq_accept,
  input wire logic [NA-1:0] group_a_pulse_outputs,
  input wire logic [NA-1:0] group_a_pulse_oe,
  input wire logic [NB-1:0] group_b_pulse_outputs,
  input wire logic [NB-1:0] group_b_pulse_oe,
  input wire logic [tpo_pkg::TPO_NFLAG-1:0] irq_request
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpo_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic pwm_on_r;
  wire logic commit = psel && penable && pready && pwrite;
  wire logic [2:0] clr_ok = irq_accept |
    ({3{commit && paddr == {24'h0, TPO_OFF_FLAGS}}} & ~pwdata[2:0]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_on_r <= 1'b0;
    end else if (commit && paddr == {24'h0, TPO_OFF_CTRL}) begin
      pwm_on_r <= pwdata[TPO_C_PWMEN];
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("no pready in first access cycle");
  misalign_a: assert property (setup_s ##0 paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  flag_hold_a: assert property ((($past(irq_request) & ~irq_request) & ~$past(clr_ok)) == 3'h0)
    else $error("request flag dropped without clear");
  ext_flag_a: assert property ($rose(irq_request[TPO_F_EXT3]) |->
    $past(ext_trigger_input) != $past(ext_trigger_input, 2) ||
    $past(ext_trigger_alt_input) != $past(ext_trigger_alt_input, 2))
    else $error("external flag without pin edge");
  cutoff_a: assert property ($fell(output_cutoff_input) |-> ##2 group_a_pulse_oe == '0)
    else $error("outputs still driven after cutoff");
  cut_hold_a: assert property ((!output_cutoff_input) [*4] |->
    {group_a_pulse_oe, group_b_pulse_oe} == '0)
    else $error("outputs driven while cutoff low");
  pins_a_a: assert property (!$stable(group_a_pulse_outputs) && !pwm_on_r |->
    $past(irq_request[TPO_F_T0] || irq_request[TPO_F_EXT3]))
    else $error("group a moved without trigger");
  pins_b_a: assert property (!$stable(group_b_pulse_outputs) && !pwm_on_r |->
    $past(irq_request[TPO_F_T3]))
    else $error("group b moved without trigger");
endmodule

// ===== sim/tpo_pins_model.sv
// Purpose: far-side pins: two trigger sources and the cutoff switch
// Assumes: levels change just after a pclk edge
// Notes: cutoff idles high, as if pulled up
module tpo_pins_model (
  input wire logic pclk,
  output logic trig_main,
  output logic trig_alt,
  output logic cut_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    trig_main = 1'b1;
    trig_alt = 1'b1;
    cut_n = 1'b1;
  end
  // p: 0 main trigger, 1 alternate, 2 cutoff; pins are device inputs only
  task automatic set_pin(input int p, input logic l);
    @(posedge pclk);
    if (p == 0) begin
      trig_main <= l;
    end else if (p == 1) begin
      trig_alt <= l;
    end else begin
      cut_n <= l;
    end
  endtask
endmodule

// ===== sim/tpo_top_tb.sv
// Purpose: self-checking bench for tpo_top over apb
// Assumes: pins driven by tpo_pins_model
// Notes: expected pins follow the data words written here
module tpo_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpo_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] irq_accept = 3'h0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_four_pwm_pin, timer_four_pwm_oe;
  logic [3:0] group_a_pulse_outputs, group_a_pulse_oe, exp_a;
  logic [1:0] group_b_pulse_outputs, group_b_pulse_oe;
  logic [2:0] irq_request;
  wire logic ext_trigger_input, ext_trigger_alt_input, output_cutoff_input;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  tpo_top i_tpo_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_trigger_input, .ext_trigger_alt_input, .output_cutoff_input,
    .irq_accept, .group_a_pulse_outputs, .group_a_pulse_oe, .group_b_pulse_outputs,
    .group_b_pulse_oe, .timer_four_pwm_pin, .timer_four_pwm_oe, .irq_request);
  tpo_pins_model i_tpo_pins_model (.pclk, .trig_main(ext_trigger_input),
    .trig_alt(ext_trigger_alt_input), .cut_n(output_cutoff_input));
  task automatic final_report();
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 50), 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
  endtask
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_request[b] !== 1'b1 && n < 300);
    chk(32'(irq_request[b]), 32'h1);
  endtask
  // next pattern goes in only once the previous edge's flag was checked
  task automatic ext_step(input int p, input logic l, input logic hit, input logic [3:0] d);
    wr(TPO_OFF_DATA0, 32'(d));
    i_tpo_pins_model.set_pin(p, l);
    repeat (4) @(posedge pclk);
    if (hit) begin
      exp_a = d;
    end
    chk(32'(group_a_pulse_outputs), 32'(exp_a));
    chk(32'(irq_request), 32'(hit) << 2);
    wr(TPO_OFF_FLAGS, 32'h0);
  endtask
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  initial begin
    logic [31:0] q;
    logic e;
    int t1, na, nt, nb;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(TPO_OFF_CTRL, 32'hffffffff, 32'h0);
    rd(TPO_OFF_T0RLD, 32'hffffffff, 32'hffff);
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h80000000);
    apb(1'b1, 8'h06, 32'h3, q, e);
    chk({e, q[30:0]}, 32'h80000000);
    rd(TPO_OFF_DATA1, 32'hffffffff, 32'h0);
    wr(TPO_OFF_CTRL, 32'h1);
    wr(TPO_OFF_CTRL, 32'h81);
    wr(TPO_OFF_DATA0, 32'ha);
    wr(TPO_OFF_DATA1, 32'h1);
    wr(TPO_OFF_T0RLD, 32'h28);
    chk(32'(group_a_pulse_outputs), 32'h0);
    wr(TPO_OFF_TSTART, 32'h1);
    wait_flag(TPO_F_T0);
    repeat (2) @(posedge pclk);
    chk(32'(group_a_pulse_outputs), 32'ha);
    chk(32'({group_a_pulse_oe, group_b_pulse_oe}), 32'h3c);
    wr(TPO_OFF_DATA0, 32'h5);
    chk(32'(group_a_pulse_outputs), 32'ha);
    rd(TPO_OFF_FLAGS, 32'h7, 32'h1);
    wr(TPO_OFF_FLAGS, 32'h0);
    wait_flag(TPO_F_T0);
    t1 = cyc;
    wr(TPO_OFF_FLAGS, 32'h6);
    wait_flag(TPO_F_T0);
    chk(32'(cyc - t1), 32'h29);
    repeat (2) @(posedge pclk);
    chk(32'(group_a_pulse_outputs), 32'h5);
    irq_accept <= 3'h1;
    @(posedge pclk);
    irq_accept <= 3'h0;
    @(posedge pclk);
    chk(32'(irq_request), 32'h0);
    wr(TPO_OFF_TSTART, 32'h0);
    wr(TPO_OFF_CTRL, 32'h89);
    wr(TPO_OFF_DATA1, 32'h2);
    wr(TPO_OFF_T3RLD, 32'h10);
    wr(TPO_OFF_TSTART, 32'h2);
    wait_flag(TPO_F_T3);
    repeat (2) @(posedge pclk);
    chk(32'({group_b_pulse_outputs, group_b_pulse_oe}), 32'hb);
    wr(TPO_OFF_TSTART, 32'h0);
    exp_a = 4'h5;
    for (int k = 0; k < 6; k++) begin
      wr(TPO_OFF_CTRL, 32'h81);
      i_tpo_pins_model.set_pin(0, 1'b1);
      i_tpo_pins_model.set_pin(1, 1'b1);
      wr(TPO_OFF_CTRL, 32'h81 | 32'((k % 3 + 1) << 4 | k / 3 << 8 | k % 3 << 9));
      wr(TPO_OFF_FLAGS, 32'h0);
      i_tpo_pins_model.set_pin(1 - k / 3, 1'b0);
      i_tpo_pins_model.set_pin(1 - k / 3, 1'b1);
      repeat (3) @(posedge pclk);
      chk(32'(irq_request), 32'h0);
      ext_step(k / 3, 1'b0, k % 3 != 1, 4'h3);
      ext_step(k / 3, 1'b1, k % 3 != 0, 4'hc);
    end
    i_tpo_pins_model.set_pin(2, 1'b0);
    repeat (4) @(posedge pclk);
    chk(32'(group_a_pulse_oe), 32'h0);
    wr(TPO_OFF_CTRL, 32'h81);
    rd(TPO_OFF_CTRL, 32'h80, 32'h0);
    i_tpo_pins_model.set_pin(2, 1'b1);
    wr(TPO_OFF_CTRL, 32'h81);
    repeat (2) @(posedge pclk);
    chk(32'(group_a_pulse_oe), 32'hf);
    wr(TPO_OFF_PWM1, 32'h702);
    wr(TPO_OFF_PWM2, 32'h702);
    wr(TPO_OFF_PWM4, 32'h702);
    wr(TPO_OFF_DATA0, 32'h5);
    wr(TPO_OFF_CTRL, 32'h1881);
    wr(TPO_OFF_FLAGS, 32'h0);
    wr(TPO_OFF_TSTART, 32'h1);
    wait_flag(TPO_F_T0);
    repeat (2) @(posedge pclk);
    na = 0;
    nt = 0;
    nb = 0;
    repeat (16) begin
      @(posedge pclk);
      na += group_a_pulse_outputs[0];
      nb += group_a_pulse_outputs[2];
      nt += timer_four_pwm_pin;
    end
    chk(32'(na), 32'h4);
    chk(32'(nb), 32'h4);
    chk(32'(nt), 32'h4);
    chk(32'({timer_four_pwm_oe, group_a_pulse_outputs[1]}), 32'h2);
    wr(TPO_OFF_CTRL, 32'h881);
    repeat (2) @(posedge pclk);
    chk(32'(timer_four_pwm_oe), 32'h0);
    // latches a=5, b=2, cutoff pin high
    rd(TPO_OFF_STAT, 32'hffffffff, 32'h65);
    // prescaler 1: one tick every two cycles doubles the period
    wr(TPO_OFF_PRESC, 32'h1);
    wr(TPO_OFF_FLAGS, 32'h0);
    wait_flag(TPO_F_T0);
    t1 = cyc;
    wr(TPO_OFF_FLAGS, 32'h0);
    wait_flag(TPO_F_T0);
    chk(32'(cyc - t1), 32'h52);
    final_report();
  end
endmodule
bind tpo_top tpo_top_asserts #(.NA(NA), .NB(NB)) i_tpo_top_asserts (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .ext_trigger_input,
  .ext_trigger_alt_input, .output_cutoff_input, .irq_accept, .group_a_pulse_outputs,
  .group_a_pulse_oe, .group_b_pulse_outputs, .group_b_pulse_oe, .irq_request);
